// ### fsp_top.sv
`timescale 1ns/1ps
module fsp_top
    import fsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [WORD_W-1:0] cmd_wdata_i,
    output logic [RDATA_W-1:0] rdata_o,
    output logic rd_valid_o,
    input wire logic [7:0] phase_sel_i,
    input wire logic [NUM_PHASES-1:0] phase_enabled_i,
    input wire logic [NUM_PHASES-1:0] phase_fault_i,
    input wire logic [WORD_W-1:0] phase_detail_i,
    input wire logic [BYTE_W-1:0] status_mfr_i,
    input wire logic [BYTE_W-1:0] status_other_i,
    input wire logic [BYTE_W-1:0] status_cml_i,
    input wire logic [BYTE_W-1:0] status_temp_i,
    input wire logic [BYTE_W-1:0] status_input_i,
    input wire logic [BYTE_W-1:0] status_iout_i,
    input wire logic [BYTE_W-1:0] status_vout_i,
    input wire logic clear_faults_i,
    output logic status_byte_cml_o,
    output logic host_alert_o,
    input wire logic [WORD_W-1:0] nvm_pg_config_i,
    input wire logic [NUM_EVENTS-1:0] event_raw_i,
    input wire logic [NUM_EVENTS-1:0] event_continue_i,
    input wire logic conv_enabled_i,
    input wire logic ton_delay_i,
    input wire logic ton_rise_i,
    input wire logic toff_fall_i,
    input wire logic fault_shutdown_i,
    output logic power_good_out_o
);
    // Command strobes
    logic wr_stb;
    logic rd_stb;
    logic ro_write;
    // Invalid command flag and start-up load
    logic invalid_command_flag_r;
    logic load_pend_r;
    // Configuration and phase flags
    logic [WORD_W-1:0] power_good_config_r;
    logic [NUM_PHASES-1:0] phase_flags_r;
    logic [NUM_PHASES-1:0] phase_flags_nxt;
    logic [NUM_PHASES-1:0] phase_clr;
    // Readback
    logic [RDATA_W-1:0] rdata_r;
    logic [RDATA_W-1:0] rdata_nxt;
    logic rd_valid_r;
    logic [BYTE_W-1:0] cml_byte;
    // Event synchroniser stages
    logic [NUM_EVENTS-1:0] ev_meta_r;
    logic [NUM_EVENTS-1:0] ev_sync_r;
    // Power-good terms
    logic [NUM_EVENTS-1:0] mask_bits;
    logic [3:0] assert_code;
    logic [3:0] release_code;
    logic active;
    logic forced_low;
    logic assert_expired;
    logic release_expired;
    fsp_pg_state_e pg_r;
    fsp_pg_state_e pg_nxt;

    // Strobes for reads and writes
    assign wr_stb = cmd_valid_i && cmd_write_i;
    assign rd_stb = cmd_valid_i && !cmd_write_i;

    // Writes that hit a read-only command
    always_comb begin
        if (wr_stb && (cmd_code_i == CMD_STATUS_BLOCK)) begin
            ro_write = 1'b1;
        end else if (wr_stb && (cmd_code_i == CMD_POWER_GOOD) && conv_enabled_i) begin
            ro_write = 1'b1;
        end else begin
            ro_write = 1'b0;
        end
    end

    // Invalid-command flag, set wins over clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            invalid_command_flag_r <= 1'b0;
        end else if (ro_write) begin
            invalid_command_flag_r <= 1'b1;
        end else if (clear_faults_i) begin
            invalid_command_flag_r <= 1'b0;
        end
    end

    // Communication status byte with the flag in its top bit
    assign cml_byte = {invalid_command_flag_r, status_cml_i[INVALID_CMD_BIT-1:0]};

    // Summary bit and host alert, registered
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            status_byte_cml_o <= 1'b0;
            host_alert_o <= 1'b0;
        end else begin
            status_byte_cml_o <= |cml_byte;
            host_alert_o <= invalid_command_flag_r;
        end
    end

    // Start-up load pending for one cycle after reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            load_pend_r <= 1'b1;
        end else begin
            load_pend_r <= 1'b0;
        end
    end

    // Power-good configuration: start-up load, then guarded writes
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            power_good_config_r <= PG_CFG_RESET;
        end else if (load_pend_r) begin
            power_good_config_r <= nvm_pg_config_i;
        end else if (wr_stb && (cmd_code_i == CMD_POWER_GOOD) && !conv_enabled_i) begin
            power_good_config_r <= cmd_wdata_i;
        end
    end

    // Write-one-to-clear of phase flags in summary mode
    always_comb begin
        phase_clr = PHASE_FLAGS_RESET;
        if (wr_stb && (cmd_code_i == CMD_PHASE_SUMMARY)) begin
            if (fsp_is_summary_sel(phase_sel_i)) begin
                phase_clr = cmd_wdata_i[NUM_PHASES-1:0];
            end
        end
    end

    // Per-phase sticky flags, set wins over clear
    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
        always_comb begin
            if (phase_fault_i[p] && phase_enabled_i[p]) begin
                phase_flags_nxt[p] = 1'b1;
            end else if (phase_clr[p] || clear_faults_i) begin
                phase_flags_nxt[p] = 1'b0;
            end else begin
                phase_flags_nxt[p] = phase_flags_r[p];
            end
        end
    end

    // Phase flag register, untouched by status block writes
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phase_flags_r <= PHASE_FLAGS_RESET;
        end else begin
            phase_flags_r <= phase_flags_nxt;
        end
    end

    // Read data selection
    always_comb begin
        if (cmd_code_i == CMD_STATUS_BLOCK) begin
            rdata_nxt = {status_mfr_i, status_other_i, cml_byte, status_temp_i,
                         status_input_i, status_iout_i, status_vout_i};
        end else if ((cmd_code_i == CMD_PHASE_SUMMARY) && fsp_is_summary_sel(phase_sel_i)) begin
            rdata_nxt = {RDATA_PAD, SUMMARY_PAD, phase_flags_r & phase_enabled_i};
        end else if (cmd_code_i == CMD_PHASE_SUMMARY) begin
            rdata_nxt = {RDATA_PAD, phase_detail_i};
        end else if (cmd_code_i == CMD_POWER_GOOD) begin
            rdata_nxt = {RDATA_PAD, power_good_config_r};
        end else begin
            rdata_nxt = RDATA_ZERO;
        end
    end

    // Read data and valid registers, one cycle after the request
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_r <= RDATA_ZERO;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_stb;
            if (rd_stb) begin
                rdata_r <= rdata_nxt;
            end
        end
    end
    assign rdata_o = rdata_r;
    assign rd_valid_o = rd_valid_r;

    // Two-stage synchroniser for detector events
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ev_meta_r <= '0;
            ev_sync_r <= '0;
        end else begin
            ev_meta_r <= event_raw_i;
            ev_sync_r <= ev_meta_r;
        end
    end

    // Configuration fields
    assign mask_bits = power_good_config_r[PG_MASK_HI:PG_MASK_LO];
    assign assert_code = power_good_config_r[PG_ASSERT_HI:PG_ASSERT_LO];
    assign release_code = power_good_config_r[PG_RELEASE_HI:PG_RELEASE_LO];

    // Unmasked events that do not keep running
    assign active = |(ev_sync_r & ~mask_bits & ~event_continue_i);

    // Sequencing states that force power-good low
    assign forced_low = !conv_enabled_i || ton_delay_i || ton_rise_i
                        || toff_fall_i || fault_shutdown_i;

    // Assert-side timer
    fsp_delay_timer u_assert_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .run_i(active),
        .code_i(assert_code),
        .expired_o(assert_expired)
    );

    // Release-side timer
    fsp_delay_timer u_release_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .run_i(!active && !forced_low),
        .code_i(release_code),
        .expired_o(release_expired)
    );

    // Power-good next state
    always_comb begin
        case (pg_r)
            FSP_PG_HIGH: begin
                if (forced_low) begin
                    pg_nxt = FSP_PG_LOW;
                end else if (assert_expired) begin
                    pg_nxt = FSP_PG_LOW;
                end else begin
                    pg_nxt = FSP_PG_HIGH;
                end
            end
            default: begin
                if (!forced_low && !assert_expired && release_expired) begin
                    pg_nxt = FSP_PG_HIGH;
                end else begin
                    pg_nxt = FSP_PG_LOW;
                end
            end
        endcase
    end

    // Power-good register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pg_r <= FSP_PG_LOW;
        end else begin
            pg_r <= pg_nxt;
        end
    end
    assign power_good_out_o = pg_r;

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_ro_write_flags;
        (wr_stb && cmd_code_i == CMD_STATUS_BLOCK) |=> invalid_command_flag_r ##1 host_alert_o;
    endproperty
    a_ro_write_flags: assert property (p_ro_write_flags)
        else $error("read-only write did not raise invalid command");

    property p_no_clear;
        (wr_stb && cmd_code_i == CMD_STATUS_BLOCK && !clear_faults_i)
            |=> ((phase_flags_r & $past(phase_flags_r)) == $past(phase_flags_r));
    endproperty
    a_no_clear: assert property (p_no_clear)
        else $error("status block write cleared a flag");

    property p_summary_read;
        (rd_stb && cmd_code_i == CMD_PHASE_SUMMARY && fsp_is_summary_sel(phase_sel_i))
            |=> rd_valid_o && (rdata_o == {RDATA_PAD, SUMMARY_PAD,
                $past(phase_flags_r) & $past(phase_enabled_i)});
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("phase summary readback wrong");

    property p_detail_read;
        (rd_stb && cmd_code_i == CMD_PHASE_SUMMARY && !fsp_is_summary_sel(phase_sel_i))
            |=> (rdata_o == {RDATA_PAD, $past(phase_detail_i)});
    endproperty
    a_detail_read: assert property (p_detail_read)
        else $error("selected phase detail readback wrong");

    property p_forced_low;
        forced_low |=> (power_good_out_o == 1'b0);
    endproperty
    a_forced_low: assert property (p_forced_low)
        else $error("power-good high while forced low");

    property p_bypass;
        (power_good_out_o && (toff_fall_i || fault_shutdown_i)) |=> !power_good_out_o;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("assert delay not bypassed");

    property p_cfg_lock;
        (!load_pend_r && wr_stb && cmd_code_i == CMD_POWER_GOOD && conv_enabled_i)
            |=> $stable(power_good_config_r) && invalid_command_flag_r;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock)
        else $error("config changed while conversion enabled");

    property p_assert_code0;
        (power_good_out_o && !forced_low && active && assert_code == DELAY_CODE_MIN)
            ##1 (active && !forced_low) |=> !power_good_out_o;
    endproperty
    a_assert_code0: assert property (p_assert_code0)
        else $error("minimum assert delay not met");

    property p_release_code0;
        (!power_good_out_o && !forced_low && !active && release_code == DELAY_CODE_MIN)
            ##1 (!active && !forced_low) |=> power_good_out_o;
    endproperty
    a_release_code0: assert property (p_release_code0)
        else $error("minimum release delay not met");

    property p_masked_hold;
        (power_good_out_o && !active && !forced_low) |=> power_good_out_o;
    endproperty
    a_masked_hold: assert property (p_masked_hold)
        else $error("power-good dropped without unmasked event");

    c_pg_fall: cover property (power_good_out_o ##1 !power_good_out_o);
    c_pg_rise: cover property (!power_good_out_o ##1 power_good_out_o);
    c_ivc_set: cover property (!invalid_command_flag_r ##1 invalid_command_flag_r);
    c_sum_read: cover property (rd_stb && cmd_code_i == CMD_PHASE_SUMMARY);
endmodule : fsp_top

// ### fsp_pkg.sv
// Shared constants and types for the fault status and power-good block
package fsp_pkg;
    // Command codes served by this block
    localparam logic [7:0] CMD_STATUS_BLOCK = 8'hdb;
    localparam logic [7:0] CMD_PHASE_SUMMARY = 8'hdc;
    localparam logic [7:0] CMD_POWER_GOOD = 8'he3;
    // Phase selections that ask for the all-phase summary
    localparam logic [7:0] PHASE_SEL_ALL = 8'hff;
    localparam logic [7:0] PHASE_SEL_ALT_ALL = 8'h80;
    // Widths
    localparam int NUM_PHASES = 4;
    localparam int NUM_EVENTS = 8;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int RDATA_W = 56;
    localparam int CNT_W = 16;
    // Field positions of the power-good configuration word
    localparam int PG_ASSERT_HI = 15;
    localparam int PG_ASSERT_LO = 12;
    localparam int PG_RELEASE_HI = 11;
    localparam int PG_RELEASE_LO = 8;
    localparam int PG_MASK_HI = 7;
    localparam int PG_MASK_LO = 0;
    // Invalid-command flag position in the communication status byte
    localparam int INVALID_CMD_BIT = 7;
    // Event and mask bit positions
    localparam int EV_OUT_OVERVOLT_FAULT = 7;
    localparam int EV_OUT_OVERVOLT_WARN = 6;
    localparam int EV_OUT_UNDERVOLT_FAULT = 5;
    localparam int EV_OUT_UNDERVOLT_WARN = 4;
    localparam int EV_OVERCURRENT_WARN = 3;
    localparam int EV_OVERCURRENT_FAULT = 2;
    localparam int EV_IN_OVERVOLT_WARN = 1;
    localparam int EV_IN_OVERVOLT_FAULT = 0;
    // Reset values and other fixed constants
    localparam logic [NUM_PHASES-1:0] PHASE_FLAGS_RESET = 4'h0;
    localparam logic [WORD_W-1:0] PG_CFG_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [3:0] DELAY_CODE_MIN = 4'h0;
    localparam logic [RDATA_W-1:0] RDATA_ZERO = 56'h0;
    localparam logic [RDATA_W-WORD_W-1:0] RDATA_PAD = 40'h0;
    localparam logic [WORD_W-NUM_PHASES-1:0] SUMMARY_PAD = 12'h000;
    // Power-good output state
    typedef enum logic {
        FSP_PG_LOW = 1'b0,
        FSP_PG_HIGH = 1'b1
    } fsp_pg_state_e;
    // Delay code to PWM clock count: 1 for code 0, else 2^N+1
    function automatic logic [CNT_W-1:0] fsp_delay_cycles(input logic [3:0] code);
        if (code == DELAY_CODE_MIN) begin
            return CNT_ONE;
        end
        return (CNT_ONE << code) + CNT_ONE;
    endfunction : fsp_delay_cycles
    // True when the phase selection asks for the summary word
    function automatic logic fsp_is_summary_sel(input logic [7:0] sel);
        return (sel == PHASE_SEL_ALL) || (sel == PHASE_SEL_ALT_ALL);
    endfunction : fsp_is_summary_sel
endpackage : fsp_pkg

// ### fsp_delay_timer.sv
`timescale 1ns/1ps
// Saturating delay counter, one instance per timed condition
module fsp_delay_timer
    import fsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [3:0] code_i,
    output logic expired_o
);
    // Count held cycles and the programmed target
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] target;

    // Target from the delay code
    assign target = fsp_delay_cycles(code_i);

    // Next count: restart on loss, hold once reached
    always_comb begin
        if (!run_i) begin
            cnt_nxt = CNT_ZERO;
        end else if (cnt_r >= target) begin
            cnt_nxt = cnt_r;
        end else begin
            cnt_nxt = cnt_r + CNT_ONE;
        end
    end

    // Counter register, one step per PWM clock
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Expired while the condition has held for the target
    assign expired_o = run_i && (cnt_r >= target);
endmodule : fsp_delay_timer

// ### fsp_host_model.sv
`timescale 1ns/1ps
// Behavioural host that issues command strobes to the block
module fsp_host_model
    import fsp_pkg::*;
(
    input wire logic clock_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [WORD_W-1:0] cmd_wdata_o,
    input wire logic [RDATA_W-1:0] rdata_i,
    input wire logic rd_valid_i
);
    // Idle bus at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h5a5a;
    end

    // Whole-word write, taken at the edge after the strobe rises
    task automatic write_word(input logic [7:0] code, input logic [WORD_W-1:0] data);
        @(posedge clock_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= 1'b1;
        cmd_code_o <= code;
        cmd_wdata_o <= data;
        @(posedge clock_i);
        cmd_valid_o <= 1'b0;
        // Released lines show a changed value, not the old one
        cmd_code_o <= ~code;
        cmd_wdata_o <= ~data;
    endtask : write_word

    // One read strobe; the answer is registered at the taking edge
    task automatic read_cmd(input logic [7:0] code, output logic [RDATA_W-1:0] data,
                            output logic got);
        @(posedge clock_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= 1'b0;
        cmd_code_o <= code;
        @(posedge clock_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code;
        #1;
        got = rd_valid_i;
        data = rdata_i;
    endtask : read_cmd
endmodule : fsp_host_model

// ### fsp_top_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the fault status and power-good block
module fsp_top_bench;
    import fsp_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid, cmd_write, rd_valid, ok, cml_o, alert_o, pg_o;
    logic clr = 1'b0;
    logic conv = 1'b0;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic [15:0] detail = 16'hc3a5;
    logic [15:0] nvm = 16'h1100;
    logic [RDATA_W-1:0] rdata, got;
    // Live status bytes, communication byte kept clear
    logic [RDATA_W-1:0] st = 56'h11220044556677;
    logic [7:0] sel = 8'h00;
    logic [7:0] ev = 8'h00;
    logic [7:0] cont = 8'h00;
    logic [3:0] pen = 4'h0;
    logic [3:0] pflt = 4'h0;
    logic [3:0] frc = 4'h0;
    int bad_count = 0;
    int tests_run = 0;
    int n0, n2, f0, f2, m;

    // Clock, 25 ns period
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    // Host on the command port
    fsp_host_model host (.clock_i(clock_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata), .rdata_i(rdata), .rd_valid_i(rd_valid));

    fsp_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
        .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
        .rdata_o(rdata), .rd_valid_o(rd_valid), .phase_sel_i(sel), .phase_enabled_i(pen),
        .phase_fault_i(pflt), .phase_detail_i(detail), .status_mfr_i(st[55:48]),
        .status_other_i(st[47:40]), .status_cml_i(st[39:32]), .status_temp_i(st[31:24]),
        .status_input_i(st[23:16]), .status_iout_i(st[15:8]), .status_vout_i(st[7:0]),
        .clear_faults_i(clr), .status_byte_cml_o(cml_o), .host_alert_o(alert_o),
        .nvm_pg_config_i(nvm), .event_raw_i(ev), .event_continue_i(cont),
        .conv_enabled_i(conv), .ton_delay_i(frc[0]), .ton_rise_i(frc[1]),
        .toff_fall_i(frc[2]), .fault_shutdown_i(frc[3]), .power_good_out_o(pg_o));

    // Delay code to clock count
    function automatic int dly(input int c);
        return (c == 0) ? 1 : (1 << c) + 1;
    endfunction : dly

    // Single compare for every result
    task automatic check(input string what, input logic [55:0] exp, input logic [55:0] seen);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Read with answer strobe check
    task automatic rd(input logic [7:0] code, input logic [55:0] exp, input string what);
        host.read_cmd(code, got, ok);
        check("read strobe", 56'h1, 56'(ok));
        check(what, exp, got);
    endtask : rd

    // Count edges until power-good reaches a level
    task automatic wait_pg(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (pg_o !== lvl && n < 200);
    endtask : wait_pg

    // Config write while stopped, then restart and time the release
    task automatic set_cfg(input logic [15:0] v, output int n);
        @(posedge clock_i);
        conv <= 1'b0;
        host.write_word(CMD_POWER_GOOD, v);
        @(posedge clock_i);
        conv <= 1'b1;
        wait_pg(1'b1, n);
    endtask : set_cfg

    // Raise one event, time the fall, then let it recover
    task automatic fall(input int b, output int n);
        int r;
        @(posedge clock_i);
        ev <= 8'h01 << b;
        wait_pg(1'b0, n);
        @(posedge clock_i);
        ev <= 8'h00;
        wait_pg(1'b1, r);
    endtask : fall

    // Power-good must stay high; events drop at edge number drop
    task automatic hold_high(input string what, input int cycles, input int drop);
        logic lo;
        lo = 1'b0;
        for (int k = 1; k <= cycles; k++) begin
            @(posedge clock_i);
            if (k == drop) ev <= 8'h00;
            #1;
            if (pg_o !== 1'b1) lo = 1'b1;
        end
        check(what, 56'h0, 56'(lo));
    endtask : hold_high

    // Clear fault flags with one pulse
    task automatic clear_all();
        @(posedge clock_i);
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
    endtask : clear_all

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        check("pg while stopped", 56'h0, 56'(pg_o));
        check("cml summary idle", 56'h0, 56'(cml_o));
        rd(CMD_POWER_GOOD, {RDATA_PAD, nvm}, "cfg from storage");
        rd(CMD_STATUS_BLOCK, st, "status block");
        host.write_word(CMD_STATUS_BLOCK, 16'hffff);
        @(posedge clock_i);
        #1;
        check("cml summary", 56'h1, 56'(cml_o));
        check("host alert", 56'h1, 56'(alert_o));
        host.write_word(CMD_STATUS_BLOCK, 16'h0000);
        rd(CMD_STATUS_BLOCK, st | 56'h00008000000000, "block after write");
        clear_all();
        @(posedge clock_i);
        st <= {8'h99, st[47:0]};
        rd(CMD_STATUS_BLOCK, {8'h99, st[47:0]}, "live block");
        // Phase flags: phase 3 disabled, faults on phases 1 and 3
        @(posedge clock_i);
        pen <= 4'h7;
        pflt <= 4'ha;
        sel <= PHASE_SEL_ALL;
        @(posedge clock_i);
        pflt <= 4'h0;
        rd(CMD_PHASE_SUMMARY, 56'h2, "summary all");
        @(posedge clock_i);
        sel <= PHASE_SEL_ALT_ALL;
        host.write_word(CMD_PHASE_SUMMARY, 16'hfff0);
        rd(CMD_PHASE_SUMMARY, 56'h2, "summary alt");
        host.write_word(CMD_PHASE_SUMMARY, 16'h0002);
        rd(CMD_PHASE_SUMMARY, 56'h0, "summary cleared");
        @(posedge clock_i);
        sel <= 8'h01;
        rd(CMD_PHASE_SUMMARY, {RDATA_PAD, detail}, "phase detail");
        // Delay codes 0 and 2, compared by their difference
        set_cfg(16'h0000, n0);
        rd(CMD_POWER_GOOD, 56'h0, "cfg written");
        fall(2, f0);
        set_cfg(16'h2200, n2);
        check("release delay", 56'(dly(2) - dly(0)), 56'(n2 - n0));
        fall(2, f2);
        check("assert delay", 56'(dly(2) - dly(0)), 56'(f2 - f0));
        host.write_word(CMD_POWER_GOOD, 16'hffff);
        rd(CMD_POWER_GOOD, {RDATA_PAD, 16'h2200}, "cfg locked");
        check("alert on locked", 56'h1, 56'(alert_o));
        clear_all();
        // Each forcing condition drops power-good at the next edge
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            if (i < 4) frc <= 4'h1 << i;
            else conv <= 1'b0;
            wait_pg(1'b0, m);
            check("forced low", 56'h1, 56'(m));
            @(posedge clock_i);
            frc <= 4'h0;
            conv <= 1'b1;
            wait_pg(1'b1, m);
        end
        // Each mask bit blocks its own event
        for (int i = 0; i < 8; i++) begin
            set_cfg({8'h00, 8'(1 << i)}, m);
            @(posedge clock_i);
            ev <= 8'(1 << i);
            hold_high("masked event", 12, 12);
        end
        // Continue-operating response keeps power-good
        set_cfg(16'h0000, m);
        @(posedge clock_i);
        cont <= 8'h04;
        ev <= 8'h04;
        hold_high("continue event", 12, 12);
        @(posedge clock_i);
        cont <= 8'h00;
        // Short pulses under the delay difference, counter restarts
        set_cfg(16'h3000, m);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            ev <= 8'h01;
            hold_high("short pulse", 4, 4);
        end
        hold_high("after pulses", 12, 12);
        close_out();
    end
endmodule : fsp_top_bench
